// *** logic/rh_desc_pkg.sv ***
/*
  Constants for the first root-hub descriptor register block: field positions,
  reset straps, command codes and timing.
  Assumes a single 125 MHz clock and a synchronous active-high reset.
*/
// Functional notes
// R1 - Bits 31..24 hold the power-good delay, one count per 2 ms.
// R2 - Software waits delay times 2 ms after powering a port before access.
// R3 - Bit 12 set means no overcurrent reporting; clear defers to bit 11.
// R4 - Bit 11 chooses collective (0) or per-port (1) overcurrent reporting.
// R5 - At reset bit 11 equals the switching granularity bit.
// R6 - Software clears bit 11 then sets it for per-port reporting.
// R7 - Compound flag bit 10 always reads 0; software writes only 0.
// R8 - Bit 9 set means ports always powered; clear means switched.
// R9 - Bit 8 chooses ganged (0) or individual (1) port switching.
// R10 - Masked ports obey per-port commands only; others follow global commands.
// R11 - Bits 1..0 give downstream port count, never above two.
// R12 - Bits 23..13 and 7..2 are reserved with no function.
// R13 - Power mask is 3 bits at 18..16; bit1 port1, bit2 port2, bit0 reserved.
// R14 - Reserved bits read 0 and ignore writes.
// R15 - Implementation-specific fields reset to design-time strap values.
package rh_desc_pkg;
  localparam int          DELAY_MSB      = 31;
  localparam int          DELAY_LSB      = 24;
  localparam int          NOCUR_BIT      = 12;
  localparam int          OCGRAN_BIT     = 11;
  localparam int          COMPOUND_BIT   = 10;
  localparam int          ALWAYS_PWR_BIT = 9;
  localparam int          SWGRAN_BIT     = 8;
  localparam int          PORTS_MSB      = 1;
  localparam int          MASK_LSB       = 16;
  localparam int          MASK_MSB       = 18;
  localparam int          MAX_PORTS      = 2;
  localparam int          DELAY_UNIT_MS  = 2;
  localparam int          CLK_MHZ        = 125;
  localparam int          UNIT_CYCLES    = DELAY_UNIT_MS * 1000 * CLK_MHZ;
  localparam logic [31:0] WRITE_MASK_A   = 32'hFF00_1B03;
  localparam logic [31:0] WRITE_MASK_B   = 32'h0007_0000;
  localparam logic [7:0]  RST_DELAY      = 8'h32;
  localparam logic        RST_NOCUR      = 1'b0;
  localparam logic        RST_ALWAYS_PWR = 1'b0;
  localparam logic        RST_SWGRAN     = 1'b1;
  localparam logic [1:0]  RST_PORTS      = 2'h2;
  localparam logic [2:0]  RST_MASK       = 3'h0;
  typedef enum logic [2:0] {
    CMD_NONE, CMD_SET_GLOBAL, CMD_CLR_GLOBAL, CMD_SET_PORT, CMD_CLR_PORT
  } power_cmd_t;
endpackage : rh_desc_pkg

// *** logic/power_good_timer.sv ***
/*
  Per-port power-good timer: after a port turns on, counts delay units of
  2 ms and then raises ready. Off clears ready at once.
  Assumes clk at the package rate; unit length is a parameter for simulation.
*/
`timescale 1ns/100ps
module power_good_timer #(
  parameter int UNIT_CYCLES = rh_desc_pkg::UNIT_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       powered,
  input  wire logic [7:0] delay_units,
  output logic            ready
);
  import rh_desc_pkg::*;
  if (UNIT_CYCLES < 1) begin : g_bad_unit
    $error("UNIT_CYCLES must be at least 1");
  end
  logic [31:0] cycle_cnt;
  logic [7:0]  unit_cnt;
  logic        powered_q;
  wire         unit_done = (cycle_cnt == 32'(UNIT_CYCLES - 1));
  always_ff @(posedge clk) begin
    if (rst || !powered) begin
      cycle_cnt <= 32'h0;
      unit_cnt  <= 8'h0;
      ready     <= 1'b0;
      powered_q <= 1'b0;
    end else begin
      powered_q <= 1'b1;
      if (!powered_q) begin
        cycle_cnt <= 32'h0;
        unit_cnt  <= 8'h0;
      end else if (unit_cnt >= delay_units) begin
        ready <= 1'b1;  // see R2
      end else if (unit_done) begin
        cycle_cnt <= 32'h0;
        unit_cnt  <= unit_cnt + 8'h1;
      end else begin
        cycle_cnt <= cycle_cnt + 32'h1;
      end
    end
  end
endmodule : power_good_timer

// *** logic/root_hub_descriptor_a.sv ***
/*
  First root-hub descriptor register with the port power mask and the power
  switching logic it steers. Software reaches both words through the host
  controller's register port: a one-cycle write strobe or read strobe with
  a select of which word.
  Assumes strobes are synchronous to clk; read data is valid the next cycle.
*/
`timescale 1ns/100ps
module root_hub_descriptor_a #(
  parameter int          NUM_PORTS   = rh_desc_pkg::MAX_PORTS,
  parameter int          UNIT_CYCLES = rh_desc_pkg::UNIT_CYCLES
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    wr_strobe,
  input  wire logic                    rd_strobe,
  input  wire logic                    sel_second,
  input  wire logic [31:0]             wr_data,
  output logic      [31:0]             rd_data,
  output logic                         rd_valid,
  input  wire rh_desc_pkg::power_cmd_t power_cmd,
  input  wire logic [1:0]              cmd_port,
  output logic      [2:1]              port_power,
  output logic      [2:1]              port_ready,
  output logic                         per_port_overcurrent,
  output logic                         overcurrent_enabled
);
  import rh_desc_pkg::*;
  if (NUM_PORTS < 1 || NUM_PORTS > MAX_PORTS) begin : g_bad_ports  // see R11
    $error("NUM_PORTS must be 1 or 2");
  end

  logic [7:0] power_good_delay;
  logic       no_overcurrent_reporting;
  logic       overcurrent_granularity;
  logic       always_powered_ports;
  logic       switching_granularity;
  logic [2:0] port_power_mask;
  logic [2:1] pwr;
  logic [2:1] next_pwr;
  logic [2:1] ready_w;

  // Register images; reserved and compound bits are constant zero
  wire [1:0] downstream_port_count = 2'(NUM_PORTS);  // see R11 see R15
  wire [31:0] word_a = {power_good_delay, 11'h0, no_overcurrent_reporting,
                        overcurrent_granularity, 1'b0, always_powered_ports,
                        switching_granularity, 6'h0, downstream_port_count};  // see R7 see R12 see R14
  wire [31:0] word_b = {13'h0, port_power_mask[2:1], 1'b0, 16'h0};  // see R13 see R14
  wire        wr_a   = wr_strobe && !sel_second;
  wire        wr_b   = wr_strobe && sel_second;
  wire [31:0] wd_a   = wr_data & WRITE_MASK_A;
  wire [31:0] wd_b   = wr_data & WRITE_MASK_B;

  always_ff @(posedge clk) begin
    if (rst) begin
      power_good_delay         <= RST_DELAY;  // see R15
      no_overcurrent_reporting <= RST_NOCUR;
      overcurrent_granularity  <= RST_SWGRAN;  // see R5
      always_powered_ports     <= RST_ALWAYS_PWR;
      switching_granularity    <= RST_SWGRAN;
      port_power_mask          <= RST_MASK;
    end else begin
      if (wr_a) begin
        power_good_delay         <= wd_a[DELAY_MSB:DELAY_LSB];  // see R1
        no_overcurrent_reporting <= wd_a[NOCUR_BIT];  // see R3
        overcurrent_granularity  <= wd_a[OCGRAN_BIT];  // see R4
        always_powered_ports     <= wd_a[ALWAYS_PWR_BIT];  // see R8
        switching_granularity    <= wd_a[SWGRAN_BIT];  // see R9
      end
      if (wr_b) begin
        port_power_mask <= {wd_b[MASK_MSB:MASK_LSB + 1], 1'b0};  // see R13
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data  <= 32'h0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_strobe;
      rd_data  <= rd_strobe ? (sel_second ? word_b : word_a) : 32'h0;
    end
  end

  // Power commands: ganged mode moves all ports; individual mode splits by mask
  wire individual = !always_powered_ports && switching_granularity;
  always_comb begin
    next_pwr = pwr;
    for (int p = 1; p <= 2; p++) begin
      if (p <= NUM_PORTS) begin
        if (!individual || !port_power_mask[p]) begin  // see R9 see R10
          if (power_cmd == CMD_SET_GLOBAL) next_pwr[p] = 1'b1;
          if (power_cmd == CMD_CLR_GLOBAL) next_pwr[p] = 1'b0;
        end
        if (individual && port_power_mask[p] && cmd_port == 2'(p)) begin  // see R10
          if (power_cmd == CMD_SET_PORT) next_pwr[p] = 1'b1;
          if (power_cmd == CMD_CLR_PORT) next_pwr[p] = 1'b0;
        end
        if (always_powered_ports) next_pwr[p] = 1'b1;  // see R8
      end else begin
        next_pwr[p] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pwr <= 2'h0;
    end else begin
      pwr <= next_pwr;
    end
  end

  for (genvar g = 1; g <= 2; g++) begin : g_timer
    power_good_timer #(.UNIT_CYCLES(UNIT_CYCLES)) u_timer (
      .clk         (clk),
      .rst         (rst),
      .powered     (pwr[g]),
      .delay_units (power_good_delay),
      .ready       (ready_w[g])
    );
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port_power           <= 2'h0;
      port_ready           <= 2'h0;
      per_port_overcurrent <= 1'b0;
      overcurrent_enabled  <= 1'b0;
    end else begin
      port_power           <= pwr;
      port_ready           <= ready_w;
      overcurrent_enabled  <= !no_overcurrent_reporting;  // see R3
      per_port_overcurrent <= !no_overcurrent_reporting && overcurrent_granularity;  // see R4
    end
  end

  // Building blocks for the multi-step checks
  sequence s_write_then_read;
    wr_a ##1 (rd_strobe && !sel_second && !wr_strobe);
  endsequence

  sequence s_global_cmd;
    power_cmd == CMD_SET_GLOBAL || power_cmd == CMD_CLR_GLOBAL;
  endsequence

  sequence s_port_cmd;
    power_cmd == CMD_SET_PORT || power_cmd == CMD_CLR_PORT;
  endsequence

  chk_compound_reads_zero : assert property (@(posedge clk) disable iff (rst)  // see R7
    rd_valid
      |-> !rd_data[COMPOUND_BIT])
    else $error("compound flag read as one");

  chk_reserved_zero : assert property (@(posedge clk) disable iff (rst)  // see R14
    rd_valid && !$past(sel_second)
      |-> rd_data[23:13] == 11'h0 && rd_data[7:2] == 6'h0)
    else $error("reserved bits of first word not zero");

  chk_word_b_reserved : assert property (@(posedge clk) disable iff (rst)  // see R14
    rd_valid && $past(sel_second)
      |-> rd_data[31:19] == 13'h0 && rd_data[15:0] == 16'h0)
    else $error("reserved bits of second word not zero");

  chk_port_count_max : assert property (@(posedge clk) disable iff (rst)  // see R11
    rd_valid && !$past(sel_second)
      |-> rd_data[1:0] <= 2'h2 && rd_data[1:0] != 2'h0)
    else $error("port count out of range");

  chk_delay_write_back : assert property (@(posedge clk) disable iff (rst)  // see R1
    s_write_then_read
      |=> rd_data[31:24] == $past(wr_data[31:24], 2))
    else $error("delay field did not store write");

  chk_oc_granular : assert property (@(posedge clk) disable iff (rst)  // see R4
    per_port_overcurrent
      |-> overcurrent_enabled && $past(overcurrent_granularity))
    else $error("per-port reporting without its mode bits");

  chk_oc_disable : assert property (@(posedge clk) disable iff (rst)  // see R3
    wr_a && wr_data[NOCUR_BIT]
      |=> ##1 !overcurrent_enabled)
    else $error("overcurrent reporting not disabled");

  chk_always_power : assert property (@(posedge clk) disable iff (rst)  // see R8
    always_powered_ports
      |=> ##1 port_power[1])
    else $error("port unpowered in always-powered mode");

  chk_port2_always : assert property (@(posedge clk) disable iff (rst)  // see R8
    always_powered_ports && NUM_PORTS == 2
      |=> ##1 port_power[2])
    else $error("second port unpowered in always-powered mode");

  chk_masked_ignores_global : assert property (@(posedge clk) disable iff (rst)  // see R10
    (individual && port_power_mask[1]) ##0 s_global_cmd
      |=> pwr[1] == $past(pwr[1]))
    else $error("masked port moved on global command");

  chk_unmasked_ignores_port : assert property (@(posedge clk) disable iff (rst)  // see R10
    (individual && !port_power_mask[2]) ##0 s_port_cmd
      |=> pwr[2] == $past(pwr[2]))
    else $error("unmasked port moved on per-port command");

  chk_ganged_set : assert property (@(posedge clk) disable iff (rst)  // see R9
    !individual && power_cmd == CMD_SET_GLOBAL
      |=> pwr[1])
    else $error("ganged set did not power port");

  chk_ready_drops_off : assert property (@(posedge clk) disable iff (rst)  // see R1
    !pwr[1]
      |=> ##1 !port_ready[1])
    else $error("port ready while unpowered");

  chk_reset_oc_mode : assert property (@(posedge clk)  // see R5
    $fell(rst)
      |-> overcurrent_granularity == switching_granularity)
    else $error("granularity bits differ after reset");

  chk_mask_bit0 : assert property (@(posedge clk) disable iff (rst)  // see R13
    rd_valid && $past(sel_second)
      |-> rd_data[16] == 1'b0)
    else $error("mask bit zero not reserved");
endmodule : root_hub_descriptor_a

// *** sim/root_hub_descriptor_a_tb.sv ***
/*
  Self-checking bench for the first root-hub descriptor register block.
  Assumes rh_desc_pkg and the design files are compiled first; one clock.
*/
`timescale 1ns/100ps
module root_hub_descriptor_a_tb;
  import rh_desc_pkg::*;
  localparam int UNITS = 4;
  logic        clk;
  logic        rst;
  logic        wr_strobe;
  logic        rd_strobe;
  logic        sel_second;
  logic [31:0] wr_data;
  logic [31:0] rd_data;
  logic        rd_valid;
  power_cmd_t  power_cmd;
  logic [1:0]  cmd_port;
  logic [2:1]  port_power;
  logic [2:1]  port_ready;
  logic        per_port_overcurrent;
  logic        overcurrent_enabled;
  int          n_errors;
  int          compares;
  int          cycles;

  root_hub_descriptor_a #(.NUM_PORTS(2), .UNIT_CYCLES(UNITS)) uut (
    .clk(clk), .rst(rst), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .sel_second(sel_second), .wr_data(wr_data), .rd_data(rd_data),
    .rd_valid(rd_valid), .power_cmd(power_cmd), .cmd_port(cmd_port),
    .port_power(port_power), .port_ready(port_ready),
    .per_port_overcurrent(per_port_overcurrent),
    .overcurrent_enabled(overcurrent_enabled));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  task automatic write_word(input logic sel, input logic [31:0] data);
    @(negedge clk);
    wr_strobe  = 1'b1;
    sel_second = sel;
    wr_data    = data;
    @(negedge clk);
    wr_strobe  = 1'b0;
    repeat (3) @(negedge clk);
  endtask : write_word

  // Read data is sampled in the cycle after the strobe edge
  task automatic read_check(input logic sel, input logic [31:0] exp);
    @(negedge clk);
    rd_strobe  = 1'b1;
    sel_second = sel;
    @(negedge clk);
    rd_strobe  = 1'b0;
    check("rd_valid", 32'h1, {31'h0, rd_valid});
    check("rd_data", exp, rd_data);
  endtask : read_check

  // Write then read the same word on the very next edge
  task automatic write_read(input logic sel, input logic [31:0] data, input logic [31:0] exp);
    @(negedge clk);
    wr_strobe  = 1'b1;
    sel_second = sel;
    wr_data    = data;
    @(negedge clk);
    wr_strobe  = 1'b0;
    rd_strobe  = 1'b1;
    @(negedge clk);
    rd_strobe  = 1'b0;
    check("rd_valid", 32'h1, {31'h0, rd_valid});
    check("rd_data", exp, rd_data);
  endtask : write_read

  task automatic command(input power_cmd_t cmd, input logic [1:0] port, input logic [2:1] exp);
    @(negedge clk);
    power_cmd = cmd;
    cmd_port  = port;
    @(negedge clk);
    power_cmd = CMD_NONE;
    @(negedge clk);
    check("port_power", {30'h0, exp}, {30'h0, port_power});
  endtask : command

  task automatic test_masks;
    read_check(1'b0, 32'h3200_0902);
    read_check(1'b1, 32'h0000_0000);
    write_word(1'b0, 32'hFFFF_FBFF);
    read_check(1'b0, 32'hFF00_1B02);
    write_word(1'b0, 32'h0000_0000);
    read_check(1'b0, 32'h0000_0002);
    write_word(1'b1, 32'hFFFF_FFFF);
    read_check(1'b1, 32'h0006_0000);
    write_read(1'b0, 32'h5A00_0002, 32'h5A00_0002);
  endtask : test_masks

  task automatic test_overcurrent;
    write_word(1'b0, 32'h3200_0802);
    check("oc_on", 32'h1, {31'h0, overcurrent_enabled});
    check("oc_port", 32'h1, {31'h0, per_port_overcurrent});
    write_word(1'b0, 32'h3200_0002);
    check("oc_port", 32'h0, {31'h0, per_port_overcurrent});
    write_word(1'b0, 32'h3200_1802);
    check("oc_on", 32'h0, {31'h0, overcurrent_enabled});
    check("oc_port", 32'h0, {31'h0, per_port_overcurrent});
  endtask : test_overcurrent

  task automatic test_power;
    write_word(1'b0, 32'h3200_0002);
    command(CMD_CLR_GLOBAL, 2'h0, 2'b00);
    command(CMD_SET_GLOBAL, 2'h0, 2'b11);
    command(CMD_CLR_GLOBAL, 2'h0, 2'b00);
    write_word(1'b0, 32'h3200_0102);
    write_word(1'b1, 32'h0002_0000);
    command(CMD_SET_GLOBAL, 2'h0, 2'b10);
    command(CMD_SET_PORT, 2'h1, 2'b11);
    command(CMD_CLR_GLOBAL, 2'h0, 2'b01);
    command(CMD_CLR_PORT, 2'h2, 2'b01);
    command(CMD_CLR_PORT, 2'h1, 2'b00);
    write_word(1'b0, 32'h3200_0202);
    check("port_power", 32'h3, {30'h0, port_power});
  endtask : test_power

  task automatic test_ready;
    int n;
    write_word(1'b0, 32'h0300_0000);
    command(CMD_CLR_GLOBAL, 2'h0, 2'b00);
    command(CMD_SET_GLOBAL, 2'h0, 2'b11);
    check("port_ready", 32'h0, {30'h0, port_ready});
    n = 2;
    while (port_ready !== 2'b11 && n < 60) begin
      @(negedge clk);
      n++;
    end
    check("ready_seen", 32'h1, {31'h0, port_ready === 2'b11});
    check("ready_late", 32'h1, {31'h0, n >= 3 * UNITS});
    check("ready_bound", 32'h1, {31'h0, n <= 3 * UNITS + 6});
  endtask : test_ready

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      summarize();
    end
  end

  initial begin
    rst = 1'b1;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    sel_second = 1'b0;
    wr_data = 32'h0000_0000;
    power_cmd = CMD_NONE;
    cmd_port = 2'h0;
    n_errors = 0;
    compares = 0;
    cycles = 0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    test_masks();
    test_overcurrent();
    test_power();
    test_ready();
    summarize();
  end
endmodule : root_hub_descriptor_a_tb
